// File: bench/dpram_port_model.sv
// Behavioural model of one port of the dual-port RAM, mailbox and tokens.
`timescale 1ns/1ps
`default_nettype none
`include "mbox_host_defines.svh"
module dpram_port_model (
  input  wire logic        sel_lo_i,
  input  wire logic        sel_hi_i,
  input  wire logic        rw_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        tok_n_i,
  input  wire logic        hi_n_i,
  input  wire logic        lo_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [17:0] wdata_i,
  input  wire logic        data_en_i,
  input  wire logic        other_mail_i,
  input  wire logic        other_busy_i,
  input  wire logic [7:0]  other_claim_i,
  output logic      [17:0] data_o,
  output logic             busy_n_o,
  output logic             int_n_o,
  output logic             far_int_o
);
  logic [17:0] mem [0:65535];
  logic [7:0]  req_r = 8'h00;
  logic [7:0]  mine_r = 8'h00;
  logic        int_r = 1'b0;
  logic        far_r = 1'b0;
  logic        mem_sel;
  logic        tok_sel;
  logic        drv;
  logic [17:0] word;
  // ===================
  // Decode and read drivers.
  assign mem_sel = !sel_lo_i && sel_hi_i && tok_n_i;
  assign tok_sel = !tok_n_i && !(!sel_lo_i && sel_hi_i);
  assign drv = !oe_n_i && (mem_sel || tok_sel);
  assign word = tok_sel ? {18{!mine_r[addr_i[2:0]]}} : mem[addr_i];
  // Lanes not driven show the inverse, so a stale value never passes.
  assign data_o[8:0] = (drv && !lo_n_i) ? word[8:0] : ~word[8:0];
  assign data_o[17:9] = (drv && !hi_n_i) ? word[17:9] : ~word[17:9];
  assign busy_n_o = !other_busy_i;
  assign int_n_o = !int_r;
  assign far_int_o = far_r;
  // ===================
  // The write lands on the rising edge of the strobe, and only while the
  // controller really drives the bus, so a dead output enable shows up.
  always @(posedge rw_n_i) begin
    if (data_en_i) begin
      if (mem_sel && !hi_n_i) mem[addr_i][17:9] = wdata_i[17:9];
      if (mem_sel && !lo_n_i) mem[addr_i][8:0] = wdata_i[8:0];
      if (tok_sel) req_r[addr_i[2:0]] = !wdata_i[0];
      // A writer that sees busy cannot raise the far port's interrupt.
      if (mem_sel && addr_i == `MBOX_RIGHT_64K && busy_n_o) begin
        far_r = 1'b1;
      end
    end
  end
  // A request wins only while the far port does not hold that token.
  always @(req_r or other_claim_i) begin
    for (int i = 0; i < 8; i++) begin
      mine_r[i] = req_r[i] && (mine_r[i] || !other_claim_i[i]);
    end
  end
  // ===================
  // Mailbox flag: the far port's write sets it, an own read clears it.
  // The delay lets all select pins settle before the read is decoded.
  always @(posedge other_mail_i or negedge oe_n_i) begin
    if (oe_n_i) begin
      int_r = 1'b1;
    end else begin
      #1;
      if (mem_sel && addr_i == `MBOX_LEFT_64K && busy_n_o) begin
        int_r = 1'b0;
      end
    end
  end
endmodule : dpram_port_model
`default_nettype wire

// File: bench/testbench.sv
// Self-checking testbench for the dual-port RAM port controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk_i, rst_i, valid, write, token, ready, done;
  logic        hit, busy, mint, psl, psh, rw_n, oe_n, tok_n, hi_n, lo_n;
  logic        bsy_n, int_n, o_mail, o_busy, doe, o_int;
  logic [7:0]  o_claim;
  logic [1:0]  lanes;
  logic [15:0] addr, pin_addr;
  logic [17:0] wdata, rdata, din, dout;
  int          failures, comparisons;
  mbox_host i_mbox_host (.mclk_i(mclk_i), .rst_i(rst_i),
    .cmd_valid_i(valid), .cmd_ready_o(ready), .cmd_write_i(write),
    .cmd_token_i(token), .cmd_addr_i(addr), .cmd_wdata_i(wdata),
    .cmd_lanes_i(lanes), .done_o(done), .rdata_o(rdata),
    .busy_hit_o(hit), .busy_o(busy), .mail_int_o(mint),
    .port_select_low_active_o(psl), .port_select_high_active_o(psh),
    .rw_n_o(rw_n), .oe_n_o(oe_n), .token_select_n_o(tok_n),
    .high_lane_select_n_o(hi_n), .low_lane_select_n_o(lo_n),
    .addr_o(pin_addr), .data_i(din), .data_o(dout), .data_oe_o(doe),
    .busy_n_i(bsy_n), .int_n_i(int_n));
  dpram_port_model u_dev (.sel_lo_i(psl), .sel_hi_i(psh), .rw_n_i(rw_n),
    .oe_n_i(oe_n), .tok_n_i(tok_n), .hi_n_i(hi_n), .lo_n_i(lo_n),
    .addr_i(pin_addr), .wdata_i(dout), .data_en_i(doe),
    .other_mail_i(o_mail), .other_busy_i(o_busy), .other_claim_i(o_claim),
    .data_o(din), .busy_n_o(bsy_n), .int_n_o(int_n), .far_int_o(o_int));
  // ===================
  // Shared tasks.
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until taken, then waits for done under a bound.
  task automatic xfer(input logic w, input logic t, input logic [15:0] a,
                      input logic [17:0] d, input logic [1:0] l);
    int n;
    write <= w;
    token <= t;
    addr <= a;
    wdata <= d;
    lanes <= l;
    valid <= 1'b1;
    // Ready and done are read at the falling edge, where they have settled.
    n = 0;
    @(negedge mclk_i);
    while (ready !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    if (ready !== 1'b1) chk(18'h0_0000, 18'h0_0001);
    @(posedge mclk_i);
    valid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (done !== 1'b1 && n < 40);
    if (done !== 1'b1) chk(18'h0_0000, 18'h0_0001);
    @(posedge mclk_i);
  endtask : xfer
  task automatic settle();
    repeat (6) @(posedge mclk_i);
  endtask : settle
  // ===================
  // Scenarios.
  task automatic s_rw();
    xfer(1, 0, 16'h0100, 18'h3_1234, 2'b11);
    xfer(0, 0, 16'h0100, 18'h0_0000, 2'b11);
    chk(rdata, 18'h3_1234);
  endtask : s_rw
  // Only the low lane is written; a low-lane-off read returns zero there.
  task automatic s_lane();
    xfer(1, 0, 16'h0100, 18'h0_0BCD, 2'b01);
    xfer(0, 0, 16'h0100, 18'h0_0000, 2'b11);
    chk(rdata, 18'h3_13CD);
    xfer(0, 0, 16'h0100, 18'h0_0000, 2'b10);
    chk(rdata, 18'h3_1200);
  endtask : s_lane
  task automatic s_mail();
    xfer(1, 0, 16'hFFFE, 18'h2_5A5A, 2'b11);
    o_busy <= 1'b1;
    xfer(1, 0, 16'hFFFF, 18'h1_0001, 2'b11);
    chk({17'h0_0000, o_int}, 18'h0_0000);
    o_busy <= 1'b0;
    xfer(1, 0, 16'hFFFF, 18'h1_0001, 2'b11);
    chk({17'h0_0000, o_int}, 18'h0_0001);
    o_mail <= 1'b1;
    @(posedge mclk_i);
    o_mail <= 1'b0;
    settle();
    chk({17'h0_0000, mint}, 18'h0_0001);
    xfer(0, 0, 16'hFFFF, 18'h0_0000, 2'b11);
    chk(rdata, 18'h1_0001);
    settle();
    chk({17'h0_0000, mint}, 18'h0_0001);
    o_busy <= 1'b1;
    settle();
    chk({17'h0_0000, busy}, 18'h0_0001);
    xfer(0, 0, 16'hFFFE, 18'h0_0000, 2'b11);
    chk({17'h0_0000, hit}, 18'h0_0001);
    settle();
    chk({17'h0_0000, mint}, 18'h0_0001);
    o_busy <= 1'b0;
    settle();
    xfer(0, 0, 16'hFFFE, 18'h0_0000, 2'b11);
    chk(rdata, 18'h2_5A5A);
    chk({17'h0_0000, hit}, 18'h0_0000);
    settle();
    chk({17'h0_0000, mint}, 18'h0_0000);
  endtask : s_mail
  // Upper address bits are set on the claim to prove they are ignored.
  task automatic s_tok();
    xfer(1, 1, 16'hABC5, 18'h0_0000, 2'b11);
    xfer(0, 1, 16'h0005, 18'h3_FFFF, 2'b11);
    chk(rdata, 18'h0_0000);
    o_claim <= 8'h24;
    xfer(0, 1, 16'h0005, 18'h3_FFFF, 2'b11);
    chk(rdata, 18'h0_0000);
    xfer(1, 1, 16'h0005, 18'h0_0001, 2'b11);
    xfer(0, 1, 16'h0005, 18'h0_0000, 2'b11);
    chk(rdata, 18'h3_FFFF);
    xfer(1, 1, 16'h0002, 18'h0_0000, 2'b11);
    xfer(0, 1, 16'h0002, 18'h0_0000, 2'b11);
    chk(rdata, 18'h3_FFFF);
    o_claim <= 8'h00;
    xfer(0, 1, 16'h0002, 18'h3_FFFF, 2'b11);
    chk(rdata, 18'h0_0000);
  endtask : s_tok
  task automatic test_done();
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // ===================
  // Clock, watchdog and main sequence.
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial begin
    #(25 * 5000);
    failures++;
    test_done();
  end
  initial begin
    {valid, write, token, o_mail, o_busy} = 5'h00;
    {lanes, addr, wdata, o_claim} = 44'h000_0000_0000;
    failures = 0;
    comparisons = 0;
    rst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    s_rw();
    s_lane();
    s_mail();
    s_tok();
    test_done();
  end
endmodule : testbench
`default_nettype wire

// File: rtl/mbox_host.sv
// Controller that drives one port of an asynchronous dual-port RAM.
`timescale 1ns/1ps
`default_nettype none
`include "mbox_host_defines.svh"
// Functional notes
// RQ1: Each port accesses memory independently, asynchronously.
// RQ2: Array holds 32K or 64K words, 16/18 bits.
// RQ3: Upper lane gates high data bits.
// RQ4: Contention flag marks same-location access.
// RQ5: Role pin chooses contention flag direction.
// RQ6: Devices combine into wider words.
// RQ7: Deselected port drops to low power.
// RQ8: Eight shared token latches exist.
// RQ9: Only one port holds a token.
// RQ10: Write data stable before ending edge.
// RQ11: Reads wait out port-to-port flow-through.
// RQ12: Reads need select and output-drive both.
// RQ13: Token access uses token select, not select.
// RQ14: Top address is right port mailbox.
// RQ15: Next address is left port mailbox.
// RQ16: Writing other mailbox raises owner interrupt.
// RQ17: Owner reading own mailbox clears interrupt.
// RQ18: Reading other mailbox leaves interrupt alone.
// RQ19: Contended mailbox write sets no interrupt.
// RQ20: Contended own-mailbox read clears nothing.
// RQ21: Mailbox content is ordinary data.
// RQ22: Token access uses three low address bits.
// RQ23: Zero on bit zero claims free token.
// RQ24: Release hands token to pending requester.
// RQ25: Role pin high makes device master.
// RQ26: Select needs low input low, high high.
// RQ27: Lane selects gate writes and read drivers.
module mbox_host #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 16
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              cmd_valid_i,
  output logic                   cmd_ready_o,
  input  wire logic              cmd_write_i,
  input  wire logic              cmd_token_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DATA_W-1:0] cmd_wdata_i,
  input  wire logic [1:0]        cmd_lanes_i,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   busy_hit_o,
  output logic                   busy_o,
  output logic                   mail_int_o,
  output logic                   port_select_low_active_o,
  output logic                   port_select_high_active_o,
  output logic                   rw_n_o,
  output logic                   oe_n_o,
  output logic                   token_select_n_o,
  output logic                   high_lane_select_n_o,
  output logic                   low_lane_select_n_o,
  output logic [ADDR_W-1:0]      addr_o,
  input  wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_o,
  input  wire logic              busy_n_i,
  input  wire logic              int_n_i
);
  import mbox_host_pkg::*;

  // Low lane is nine bits wide on the wide variant, eight otherwise.
  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
    logic [DATA_W-1:0] m;
    int                lo_w;
    m    = '0;
    lo_w = (DATA_W == `WIDE_DATA_W) ? `LANE_LO_W_WIDE : `LANE_LO_W_NARROW;
    for (int i = 0; i < DATA_W; i++) begin
      m[i] = (i < lo_w) ? lanes[`LANE_LO] : lanes[`LANE_HI];
    end
    return m;
  endfunction : lane_mask

  // ========================================================================
  // Pin synchronisers.
  logic [DATA_W-1:0] dat_s1_r, dat_s2_r, dat_s3_r;
  logic [2:0]        bsy_r, bsy_nxt, int_r, int_nxt;
  logic              busy_st_r, busy_st_nxt, int_st_r, int_st_nxt;

  // A level counts only once stages two and three agree, so a glitch
  // caught by the first stage never reaches the sequencer.
  always_comb begin
    bsy_nxt     = {bsy_r[1:0], ~busy_n_i};
    int_nxt     = {int_r[1:0], ~int_n_i};
    busy_st_nxt = (bsy_r[1] == bsy_r[2]) ? bsy_r[2] : busy_st_r;
    int_st_nxt  = (int_r[1] == int_r[2]) ? int_r[2] : int_st_r;
  end

  // Synchroniser registers; the data bus is sampled the same way.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bsy_r     <= 3'h0;
      int_r     <= 3'h0;
      busy_st_r <= 1'b0;
      int_st_r  <= 1'b0;
      dat_s1_r  <= '0;
      dat_s2_r  <= '0;
      dat_s3_r  <= '0;
    end else begin
      bsy_r     <= bsy_nxt;
      int_r     <= int_nxt;
      busy_st_r <= busy_st_nxt;
      int_st_r  <= int_st_nxt;
      dat_s1_r  <= data_i;
      dat_s2_r  <= dat_s1_r;
      dat_s3_r  <= dat_s2_r;
    end
  end

  // ========================================================================
  // Access sequencer.
  state_type         st_r, st_nxt;
  logic [7:0]        cnt_r, cnt_nxt;
  logic              wr_r, wr_nxt, tok_r, tok_nxt, hit_r, hit_nxt;
  logic              done_r, done_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0]        ln_r, ln_nxt;

  // Next-state logic; counters load the pin timings in cycles.
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wr_nxt   = wr_r;
    tok_nxt  = tok_r;
    hit_nxt  = hit_r;
    done_nxt = 1'b0;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    ln_nxt   = ln_r;
    unique case (st_r)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          st_nxt  = ST_SETUP;
          wr_nxt  = cmd_write_i;
          tok_nxt = cmd_token_i;
          hit_nxt = 1'b0;
          ln_nxt  = cmd_token_i ? 2'h3 : cmd_lanes_i;
          addr_nxt = cmd_addr_i;
          if (cmd_token_i) begin
            addr_nxt = '0; // RQ22
            addr_nxt[`TOKEN_ADDR_W-1:0] =
              cmd_addr_i[`TOKEN_ADDR_W-1:0]; // RQ22
          end
          // Only bit zero matters to a token; the rest are driven low.
          wd_nxt = cmd_token_i ? {{(DATA_W-1){1'b0}}, cmd_wdata_i[0]}
                               : cmd_wdata_i; // RQ23
        end
      end
      ST_SETUP: begin
        st_nxt  = wr_r ? ST_STROBE : ST_READ_WAIT;
        cnt_nxt = wr_r ? 8'(`WP_CYC) : 8'(`RD_CYC); // RQ11
      end
      ST_STROBE: begin
        hit_nxt = hit_r | busy_st_r; // RQ4
        if (cnt_r <= 8'h01) begin
          st_nxt = ST_RECOVER;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_RECOVER: begin
        // Data stays driven one cycle past the write's rising edge.
        st_nxt   = ST_GAP; // RQ10
        cnt_nxt  = 8'(`SOP_CYC);
        done_nxt = 1'b1;
      end
      ST_READ_WAIT: begin
        hit_nxt = hit_r | busy_st_r; // RQ4
        if (cnt_r > 8'h01) begin
          cnt_nxt = cnt_r - 8'h01;
        end else if (dat_s2_r == dat_s3_r) begin
          // Undriven lanes float, so they are masked to zero.
          rd_nxt   = dat_s3_r & lane_mask(ln_r); // RQ27
          st_nxt   = ST_GAP;
          cnt_nxt  = 8'(`SOP_CYC);
          done_nxt = 1'b1;
        end
      end
      ST_GAP: begin
        // All strobes stay off for the token recovery time.
        if (cnt_r <= 8'h01) begin
          st_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r   <= ST_IDLE;
      cnt_r  <= 8'h00;
      wr_r   <= 1'b0;
      tok_r  <= 1'b0;
      hit_r  <= 1'b0;
      done_r <= 1'b0;
      addr_r <= '0;
      wd_r   <= '0;
      rd_r   <= '0;
      ln_r   <= 2'h0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      wr_r   <= wr_nxt;
      tok_r  <= tok_nxt;
      hit_r  <= hit_nxt;
      done_r <= done_nxt;
      addr_r <= addr_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      ln_r   <= ln_nxt;
    end
  end

  // ========================================================================
  // Pin drive.
  logic active;
  assign active = (st_r == ST_SETUP) || (st_r == ST_STROBE) ||
                  (st_r == ST_RECOVER) || (st_r == ST_READ_WAIT);

  // Outside an access both selects are off so the port can power down.
  assign port_select_low_active_o  = ~(active & ~tok_r); // RQ26 RQ7
  assign port_select_high_active_o = active & ~tok_r; // RQ26 RQ13
  assign token_select_n_o          = ~(active & tok_r); // RQ13
  assign oe_n_o       = ~(active & ~wr_r); // RQ12
  assign rw_n_o       = ~(st_r == ST_STROBE); // RQ10
  assign high_lane_select_n_o = ~(active & ln_r[`LANE_HI]); // RQ3
  assign low_lane_select_n_o  = ~(active & ln_r[`LANE_LO]); // RQ3
  assign addr_o       = addr_r;
  assign data_o       = wd_r;
  assign data_oe_o    = active & wr_r;
  assign cmd_ready_o  = (st_r == ST_IDLE);
  assign done_o       = done_r;
  assign rdata_o      = rd_r;
  assign busy_hit_o   = hit_r;
  assign busy_o       = busy_st_r;
  assign mail_int_o   = int_st_r; // RQ17

  // ========================================================================
  // Checks on the pins this controller drives.
  a_select_excl: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(port_select_high_active_o && !token_select_n_o)) // RQ13
    else $error("memory select and token select both active");

  a_read_strobes: assert property (@(posedge mclk_i) disable iff (rst_i)
    !oe_n_o |-> (port_select_high_active_o && !port_select_low_active_o)
             || !token_select_n_o) // RQ12
    else $error("output drive without a select");

  a_write_edge: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(rw_n_o) |-> data_oe_o && $stable(data_o)
                      && $past(data_oe_o, 2)) // RQ10
    else $error("write ended without stable driven data");

  a_read_wait: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(done_o) && !wr_r |-> !$past(oe_n_o, 2) && !$past(oe_n_o, 4)
                               && !$past(oe_n_o, 6)) // RQ11
    else $error("read finished before flow-through wait");

  a_idle_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_ready_o |-> port_select_low_active_o && token_select_n_o
                    && oe_n_o && rw_n_o && !data_oe_o) // RQ7
    else $error("strobes active while idle");
endmodule : mbox_host
`default_nettype wire

// File: rtl/mbox_host_defines.svh
// Timing and layout constants for the dual-port RAM port controller.
`ifndef MBOX_HOST_DEFINES_SVH
`define MBOX_HOST_DEFINES_SVH
// ==========================================================================
// Clock rate and printed or chosen pin timings.
`define MCLK_MHZ        40
`define T_ACC_NS        25
`define T_WP_NS         20
`define T_DDD_NS        35
`define T_SOP_NS        15
`define SYNC_STAGES     3
// ==========================================================================
// Cycle counts derived from the times; least times round up.
`define ACC_CYC  ((`T_ACC_NS * `MCLK_MHZ + 999) / 1000)
`define WP_CYC   ((`T_WP_NS * `MCLK_MHZ + 999) / 1000)
`define DDD_CYC  ((`T_DDD_NS * `MCLK_MHZ + 999) / 1000)
`define SOP_CYC  ((`T_SOP_NS * `MCLK_MHZ + 999) / 1000)
`define RD_CYC   (`ACC_CYC + `DDD_CYC + `SYNC_STAGES)
// ==========================================================================
// Mailbox word addresses and token address width.
`define MBOX_RIGHT_32K  16'h7FFF
`define MBOX_LEFT_32K   16'h7FFE
`define MBOX_RIGHT_64K  16'hFFFF
`define MBOX_LEFT_64K   16'hFFFE
`define TOKEN_ADDR_W    3
`define WIDE_DATA_W     18
`define LANE_HI         1
`define LANE_LO         0
`define LANE_LO_W_WIDE  9
`define LANE_LO_W_NARROW 8
`endif

// File: rtl/mbox_host_pkg.sv
// Types shared by the dual-port RAM port controller.
package mbox_host_pkg;
  // ========================================================================
  // Sequencer states for one pin-level access.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER,
    ST_READ_WAIT,
    ST_GAP
  } state_type;
endpackage : mbox_host_pkg
